// ### rtl/stop_mode_periodic_wakeup.sv
// Purpose : periodic wakeup unit active only in stop mode
// Assumes : APB slave, 10 MHz clock, synchronous active-low reset
// Notes   : oscillator modelled as the system clock, gated by mode
`default_nettype none
module stop_mode_periodic_wakeup
  import wakeup_pkg::*;
#(
  parameter int CNT_WIDTH = 32
)
(
  // clock and reset
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RSTN_IN,
  // apb slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // port a pins, bits 0..5
  input  wire logic [5:0]  PORTA_PIN_IN,
  output logic      [5:0]  PORTA_PIN_OUT,
  output logic      [5:0]  PORTA_OE_OUT,
  // wakeup and interrupts
  output logic             KBD_WAKEUP_OUT,
  output logic             IRQ_OUT
);
  // elaboration check: the read mux only shows 32 bits of count
  if (CNT_WIDTH < 2 || CNT_WIDTH > 32)
  begin
    $error("stop_mode_periodic_wakeup: CNT_WIDTH out of range");
  end

  // ==========================================================
  // state
  logic [5:0]         porta_data_q;
  logic [5:0]         porta_dir_q;
  logic [5:0]         pin_meta_q;
  logic [5:0]         pin_sync_q;
  logic               latch_q;
  logic               latch_d;
  logic               kbd_mask_q;
  logic               wkie_q;
  logic               stop_req_q;
  logic               wait_req_q;
  power_mode_t        mode_q;
  power_mode_t        mode_d;
  logic [1:0]         evt_q;
  logic [1:0]         evt_d;
  logic [1:0]         evt_mask_q;
  logic [CNT_WIDTH-1:0] period_q;
  logic [CNT_WIDTH-1:0] count_w;
  logic               terminal_w;
  logic               access_done_q;

  // ==========================================================
  // apb decode
  wire apb_acc  = PSEL_IN && PENABLE_IN && !access_done_q;
  wire wr_en    = apb_acc && PWRITE_IN;
  wire rd_en    = apb_acc && !PWRITE_IN;
  wire hit_pa   = (PADDR_IN == PORTA_DATA_OFS);
  wire hit_kbs  = (PADDR_IN == KBD_STATUS_OFS);
  wire hit_ien  = (PADDR_IN == KBD_IRQ_EN_OFS);
  wire hit_mode = (PADDR_IN == MODE_CTRL_OFS);
  wire hit_evs  = (PADDR_IN == EVT_STATUS_OFS);
  wire hit_evm  = (PADDR_IN == EVT_MASK_OFS);
  wire hit_per  = (PADDR_IN == PERIOD_OFS);
  wire hit_cnt  = (PADDR_IN == COUNT_OFS);
  wire hit_any  = hit_pa || hit_kbs || hit_ien || hit_mode ||
                  hit_evs || hit_evm || hit_per || hit_cnt;

  // ack write clears the latch
  wire ack_wr   = wr_en && hit_kbs && PWDATA_IN[ACK_BIT];

  // ==========================================================
  // power mode: stop wins over wait, run when neither asked
  assign mode_d = stop_req_q ? MODE_STOP :
                  wait_req_q ? MODE_WAIT : MODE_RUN;
  wire in_stop    = (mode_q == MODE_STOP);
  // counter idle in run and wait
  // enable alone arms the unit on stop entry
  wire unit_run   = in_stop && wkie_q;
  // restart on each stop entry
  wire stop_entry = (mode_d == MODE_STOP) && !in_stop;

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RSTN_IN)
      mode_q <= MODE_RUN;
    else
      mode_q <= mode_d;
  end

  wakeup_counter #(
    .WIDTH (CNT_WIDTH)
  ) u_counter (
    .clk_in       (CLK_SYS_IN),
    .rstn_in      (RSTN_IN),
    .run_in       (unit_run),
    .restart_in   (stop_entry),
    .period_in    (period_q),
    .count_out    (count_w),
    .terminal_out (terminal_w)
  );

  // ==========================================================
  // latch: set wins over the ack clear so no request is lost
  assign latch_d = terminal_w ? 1'b1 :
                   ack_wr     ? 1'b0 : latch_q;

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RSTN_IN)
      latch_q <= 1'b0;
    else
      latch_q <= latch_d;
  end

  // request to the keyboard path needs the mask cleared
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RSTN_IN)
      KBD_WAKEUP_OUT <= 1'b0;
    else
      KBD_WAKEUP_OUT <= latch_d && wkie_q && !kbd_mask_q;
  end

  // ==========================================================
  // control registers
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RSTN_IN)
    begin
      kbd_mask_q <= 1'b1;
      wkie_q     <= 1'b0;
      stop_req_q <= 1'b0;
      wait_req_q <= 1'b0;
      period_q   <= PERIOD_RST[CNT_WIDTH-1:0];
      evt_mask_q <= 2'b00;
    end
    else if (wr_en)
    begin
      if (hit_kbs)
        kbd_mask_q <= PWDATA_IN[MASK_BIT];
      else if (hit_ien)
        wkie_q <= PWDATA_IN[WKIE_BIT];
      else if (hit_mode)
      begin
        stop_req_q <= PWDATA_IN[STOP_BIT];
        wait_req_q <= PWDATA_IN[WAIT_BIT];
      end
      else if (hit_per)
        period_q <= PWDATA_IN[CNT_WIDTH-1:0];
      else if (hit_evm)
        evt_mask_q <= PWDATA_IN[1:0];
    end
  end

  // ==========================================================
  // port a bits 0..5; bit 6 has no storage at all
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RSTN_IN)
    begin
      porta_data_q <= 6'h00;
      porta_dir_q  <= 6'h00;
    end
    else if (wr_en && hit_pa)
    begin
      porta_data_q <= PWDATA_IN[PORTA_WIDTH-1:0];  // bit 6 ignored
      porta_dir_q  <= PWDATA_IN[PORTA_WIDTH+7:8];
    end
  end

  // pins come from outside: two-stage synchroniser
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RSTN_IN)
    begin
      pin_meta_q <= 6'h00;
      pin_sync_q <= 6'h00;
    end
    else
    begin
      pin_meta_q <= PORTA_PIN_IN;
      pin_sync_q <= pin_meta_q;
    end
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RSTN_IN)
    begin
      PORTA_PIN_OUT <= 6'h00;
      PORTA_OE_OUT  <= 6'h00;
    end
    else
    begin
      PORTA_PIN_OUT <= porta_data_q;
      PORTA_OE_OUT  <= porta_dir_q;
    end
  end

  // ==========================================================
  // events: bit0 wakeup, bit1 ack; status cleared by its read,
  // but a new event in that cycle still sets its bit
  wire [1:0] evt_set = {ack_wr, terminal_w};
  assign evt_d = evt_set | ((rd_en && hit_evs) ? 2'b00 : evt_q);

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RSTN_IN)
    begin
      evt_q   <= 2'b00;
      IRQ_OUT <= 1'b0;
    end
    else
    begin
      evt_q   <= evt_d;
      // a mask bit set to one keeps its event off the irq line
      IRQ_OUT <= |(evt_d & ~evt_mask_q);
    end
  end

  // ==========================================================
  // read mux; latch shown whatever the enable is
  wire [7:0] pa_byte = {1'b0, latch_q, 2'b00, 4'h0} |
                       {2'b00, (porta_dir_q & porta_data_q) |
                               (~porta_dir_q & pin_sync_q)};
  wire [31:0] rd_word =
    hit_pa   ? {16'h0000, 2'b00, porta_dir_q, pa_byte} :
    hit_kbs  ? {30'h0000_0000, kbd_mask_q, 1'b0} :
    hit_ien  ? {30'h0000_0000, wkie_q, 1'b0} :
    hit_mode ? {29'h0000_0000, mode_q} :
    hit_evs  ? {30'h0000_0000, evt_q} :
    hit_evm  ? {30'h0000_0000, evt_mask_q} :
    hit_per  ? 32'(period_q) :
    hit_cnt  ? 32'(count_w) : ZERO_WORD;

  // one wait state: pready registered, so answers come one cycle on
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RSTN_IN)
    begin
      PREADY_OUT    <= 1'b0;
      PSLVERR_OUT   <= 1'b0;
      PRDATA_OUT    <= ZERO_WORD;
      access_done_q <= 1'b0;
    end
    else
    begin
      PREADY_OUT    <= apb_acc;
      PSLVERR_OUT   <= apb_acc && !hit_any;
      access_done_q <= apb_acc;
      if (rd_en)
        PRDATA_OUT <= rd_word;
    end
  end

  // ==========================================================
  // checks
  AST_LATCH_SET: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RSTN_IN) terminal_w |=> latch_q)
    else $error("latch not set after terminal count");
  AST_LATCH_ACK: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RSTN_IN) ack_wr && !terminal_w |=> !latch_q)
    else $error("ack write did not clear latch");
  AST_LATCH_HOLD: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RSTN_IN)
    latch_q && !ack_wr |=> latch_q)
    else $error("latch dropped without ack");
  AST_RESET_CLR: assert property (@(posedge CLK_SYS_IN)
    !RSTN_IN |=> !latch_q)
    else $error("reset did not clear latch");
  AST_RUN_IDLE: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RSTN_IN)
    mode_q == MODE_RUN && $past(mode_q) == MODE_RUN
      |-> $stable(count_w) && !terminal_w)
    else $error("counter moved in run mode");
  AST_WAIT_IDLE: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RSTN_IN)
    mode_q == MODE_WAIT && $past(mode_q) == MODE_WAIT
      |-> $stable(count_w) && !terminal_w)
    else $error("counter moved in wait mode");
  AST_AUTO_START: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RSTN_IN)
    in_stop && wkie_q && !stop_entry && count_w < period_q
      |=> count_w == $past(count_w) + 1'b1)
    else $error("counter not running in stop");
  AST_RESTART: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RSTN_IN) stop_entry |=> count_w == '0)
    else $error("counter not zero on stop entry");
  AST_READ_FLAG: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RSTN_IN)
    rd_en && hit_pa |=> PRDATA_OUT[LATCH_BIT] == $past(latch_q))
    else $error("port a bit 6 does not show latch");
  AST_NO_STORE: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RSTN_IN)
    wr_en && hit_pa && !terminal_w |=> latch_q == $past(latch_q))
    else $error("write to port a changed latch");

  // request follows the latch; terminal counts only come from stop
  AST_WAKE_REQ: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RSTN_IN) KBD_WAKEUP_OUT |-> latch_q)
    else $error("wakeup request without latch");
  AST_STOP_ONLY: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RSTN_IN) terminal_w |-> $past(in_stop))
    else $error("terminal count outside stop");
  AST_WAIT_NO_REQ: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RSTN_IN) mode_q == MODE_WAIT |=> !terminal_w)
    else $error("terminal count in wait mode");
  AST_KBD_MASKED: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RSTN_IN) kbd_mask_q |=> !KBD_WAKEUP_OUT)
    else $error("wakeup request passed the keyboard mask");

  COV_WAKEUP: cover property (@(posedge CLK_SYS_IN) terminal_w);
  COV_ACK:    cover property (@(posedge CLK_SYS_IN) latch_q ##1 ack_wr);
  COV_RACE:   cover property (@(posedge CLK_SYS_IN) terminal_w && ack_wr);
  COV_IRQ:    cover property (@(posedge CLK_SYS_IN) KBD_WAKEUP_OUT);
  COV_WAIT:   cover property (@(posedge CLK_SYS_IN) mode_q == MODE_WAIT);
endmodule
`default_nettype wire

// ### rtl/wakeup_pkg.sv
// Purpose : constants for the stop mode periodic wakeup unit
// Assumes : 32-bit APB register bus, one aligned word per register
// Notes   : offsets are byte addresses
`default_nettype none
package wakeup_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] PORTA_DATA_OFS   = 8'h00;
  localparam logic [7:0] KBD_STATUS_OFS   = 8'h04;
  localparam logic [7:0] KBD_IRQ_EN_OFS   = 8'h08;
  localparam logic [7:0] MODE_CTRL_OFS    = 8'h0C;
  localparam logic [7:0] EVT_STATUS_OFS   = 8'h10;
  localparam logic [7:0] EVT_MASK_OFS     = 8'h14;
  localparam logic [7:0] PERIOD_OFS       = 8'h18;
  localparam logic [7:0] COUNT_OFS        = 8'h1C;
  // ==========================================================
  // field positions
  localparam int LATCH_BIT     = 6;  // port a bit of the latch flag
  localparam int ACK_BIT       = 2;  // keyboard ack bit
  localparam int MASK_BIT      = 1;  // keyboard interrupt mask
  localparam int WKIE_BIT      = 1;  // wakeup interrupt enable
  localparam int STOP_BIT      = 0;  // mode control: stop request
  localparam int WAIT_BIT      = 1;  // mode control: wait request
  localparam int PORTA_WIDTH   = 6;  // bits 0..5 are plain port bits
  // ==========================================================
  // reset values
  localparam logic [31:0] PERIOD_RST = 32'h0000_0400;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
  // ==========================================================
  // power modes
  typedef enum logic [2:0]
  {
    MODE_RUN  = 3'b001,
    MODE_WAIT = 3'b010,
    MODE_STOP = 3'b100
  } power_mode_t;
endpackage
`default_nettype wire

// ### rtl/wakeup_counter.sv
// Purpose : wakeup counter, runs only while enabled
// Assumes : single clock, synchronous active-low reset
// Notes   : restart pulse returns count to zero
`default_nettype none
module wakeup_counter
  import wakeup_pkg::*;
#(
  parameter int WIDTH = 32
)
(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  // control
  input  wire logic             run_in,
  input  wire logic             restart_in,
  input  wire logic [WIDTH-1:0] period_in,
  // status
  output logic      [WIDTH-1:0] count_out,
  output logic                  terminal_out
);
  // elaboration check: refuse widths the wrap logic cannot serve
  if (WIDTH < 2 || WIDTH > 32)
  begin
    $error("wakeup_counter: WIDTH out of range");
  end

  logic [WIDTH-1:0] count_d;
  wire              at_end = (count_out >= period_in);

  // ==========================================================
  // next count; wraps at the period so requests repeat
  assign count_d = restart_in ? '0 :
                   !run_in    ? count_out :
                   at_end     ? '0 : count_out + 1'b1;

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      count_out <= '0;
    else
      count_out <= count_d;
  end

  // one-cycle pulse when the terminal count is passed
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      terminal_out <= 1'b0;
    else
      terminal_out <= run_in && !restart_in && at_end;
  end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Purpose : self-checking bench for the stop mode periodic wakeup unit
// Assumes : APB at 10 MHz, synchronous active-low reset, 1 wait state
// Notes   : event mask bit high blocks that event from the irq line
`default_nettype none
module tb_top
  import wakeup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // signals
  logic        clk, rstn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, wake, irq;
  logic [5:0]  pin_in, pin_out, oe_out;
  int          num_errors = 0;
  int          num_checks = 0;
  logic [31:0] d;
  logic        e;

  // clock and reset pins
  initial clk = 1'b0;
  always #50 clk = ~clk;
  initial
  begin
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; pin_in = 6'h15;
  end

  stop_mode_periodic_wakeup DUT (
    .CLK_SYS_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .PORTA_PIN_IN(pin_in),
    .PORTA_PIN_OUT(pin_out), .PORTA_OE_OUT(oe_out),
    .KBD_WAKEUP_OUT(wake), .IRQ_OUT(irq));

  // ==========================================================
  // helpers
  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
    paddr <= a; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, d, e);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000, d, e);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  // bounded wait for the wakeup request to rise
  task automatic wait_wake();
    int n;
    n = 0;
    while (wake !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk(32'(wake), 0); chk(32'(irq), 0);
    rd(MODE_CTRL_OFS);  chk(d, 32'h0000_0001);
    rd(PERIOD_OFS);     chk(d, PERIOD_RST);
    rd(PORTA_DATA_OFS); chk(32'(d[LATCH_BIT]), 0);
    rd(KBD_STATUS_OFS); chk(32'(d[MASK_BIT]), 1);
    apb(1'b0, 8'h40, 32'h0000_0000, d, e);
    chk(32'(e), 1); chk(d, 0);
  endtask

  // bit 6 and its would-be direction bit hold nothing
  task automatic t_port();
    wr(PORTA_DATA_OFS, 32'h0000_7F6A);
    chk(32'(oe_out), 32'h0000_003F); chk(32'(pin_out), 32'h0000_002A);
    rd(PORTA_DATA_OFS); chk(d & 32'h0000_4040, 0);
    chk(d, 32'h0000_3F2A);
    // direction off: pins read back through the synchroniser
    wr(PORTA_DATA_OFS, 32'h0000_0000);
    rd(PORTA_DATA_OFS);
    chk(d, 32'h0000_0015);
    chk(32'(oe_out), 32'h0000_0000);
  endtask

  // run and wait modes and a disabled unit stay idle
  task automatic t_idle();
    wr(PERIOD_OFS, 32'h0000_0008);
    wr(KBD_STATUS_OFS, 32'h0000_0000);
    wr(KBD_IRQ_EN_OFS, 32'h0000_0002);
    cycles(40);
    rd(COUNT_OFS); chk(d, 0);
    wr(MODE_CTRL_OFS, 32'h0000_0002);
    cycles(40);
    rd(COUNT_OFS); chk(d, 0);
    rd(PORTA_DATA_OFS); chk(32'(d[LATCH_BIT]), 0);
    wr(MODE_CTRL_OFS, 32'h0000_0000);
    wr(KBD_IRQ_EN_OFS, 32'h0000_0000);
    wr(MODE_CTRL_OFS, 32'h0000_0001);
    cycles(40);
    chk(32'(wake), 0);
    rd(PORTA_DATA_OFS); chk(32'(d[LATCH_BIT]), 0);
    wr(MODE_CTRL_OFS, 32'h0000_0000);
  endtask

  // wakeup, sticky latch, masking, clear on read, ack
  task automatic t_wake();
    wr(EVT_MASK_OFS, 32'hFFFF_FFFF);
    wr(KBD_IRQ_EN_OFS, 32'h0000_0002);
    wr(MODE_CTRL_OFS, 32'h0000_0001);
    wait_wake();
    chk(32'(wake), 1);
    chk(32'(irq), 0);
    wr(PORTA_DATA_OFS, 32'h0000_0000);
    rd(PORTA_DATA_OFS); chk(32'(d[LATCH_BIT]), 1);
    wr(KBD_IRQ_EN_OFS, 32'h0000_0000);
    wr(MODE_CTRL_OFS, 32'h0000_0000);
    rd(PORTA_DATA_OFS); chk(32'(d[LATCH_BIT]), 1);
    wr(EVT_MASK_OFS, 32'h0000_0000);
    chk(32'(irq), 1);
    rd(EVT_STATUS_OFS); chk(32'(d[0]), 1);
    cycles(1);
    chk(32'(irq), 0);
    wr(KBD_STATUS_OFS, 32'h0000_0004);
    rd(PORTA_DATA_OFS); chk(32'(d[LATCH_BIT]), 0);
    chk(32'(irq), 1);
    rd(EVT_STATUS_OFS);
    chk(d, 32'h0000_0002);
  endtask

  // count restarts from zero on each stop entry
  task automatic t_restart();
    wr(PERIOD_OFS, 32'h0000_0400);
    wr(KBD_IRQ_EN_OFS, 32'h0000_0002);
    wr(MODE_CTRL_OFS, 32'h0000_0001);
    cycles(200);
    rd(COUNT_OFS); chk(32'(d > 32'd100), 1);
    wr(MODE_CTRL_OFS, 32'h0000_0000);
    wr(MODE_CTRL_OFS, 32'h0000_0001);
    rd(COUNT_OFS); chk(32'(d < 32'd16), 1);
    wr(MODE_CTRL_OFS, 32'h0000_0000);
  endtask

  // a reset in mid-run drops the latch
  task automatic t_rerst();
    wr(PERIOD_OFS, 32'h0000_0008);
    wr(MODE_CTRL_OFS, 32'h0000_0001);
    wait_wake();
    chk(32'(wake), 1);
    rstn <= 1'b0;
    cycles(3);
    rstn <= 1'b1;
    cycles(1);
    chk(32'(wake), 0);
    rd(PORTA_DATA_OFS); chk(32'(d[LATCH_BIT]), 0);
    rd(MODE_CTRL_OFS); chk(d, 32'h0000_0001);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    cycles(3);
    rstn <= 1'b1;
    cycles(1);
    t_reset();
    t_port();
    t_idle();
    t_wake();
    t_restart();
    t_rerst();
    stop_test();
  end

  // generous bound: the sequence needs about five hundred cycles
  initial
  begin
    cycles(20000);
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
